// *** rtl/fpsu_defines.svh ***
`ifndef FPSU_DEFINES_SVH
`define FPSU_DEFINES_SVH

// ----------------------------------------------------------------------
// Status and control word fields
// ----------------------------------------------------------------------
`define FPSU_RND_MSB        23
`define FPSU_RND_LSB        22
`define FPSU_STEP_MSB       21
`define FPSU_STEP_LSB       20
`define FPSU_CNT_MSB        18
`define FPSU_CNT_LSB        16
`define FPSU_DENORM_BIT     7
`define FPSU_INEXACT_BIT    4
`define FPSU_UNDER_BIT      3
`define FPSU_OVER_BIT       2
`define FPSU_DIVZ_BIT       1
`define FPSU_INVALID_BIT    0
`define FPSU_FLAG_COUNT     6
`define FPSU_STATUS_RST     32'h0000_0000

// ----------------------------------------------------------------------
// Unit enable in the exception control word
// ----------------------------------------------------------------------
`define FPSU_EN_BIT         30
`define FPSU_EN_RST         1'b0

// ----------------------------------------------------------------------
// Coprocessor access field codes
// ----------------------------------------------------------------------
`define FPSU_CP_PRIV_ONLY   2'h1
`define FPSU_CP_FULL        2'h3

// ----------------------------------------------------------------------
// Feature word zero nibbles, top down
// ----------------------------------------------------------------------
`define FPSU_FW0_ROUND      4'h1
`define FPSU_FW0_SHORTVEC   4'h0
`define FPSU_FW0_SQRT       4'h1
`define FPSU_FW0_DIVIDE     4'h1
`define FPSU_FW0_TRAP       4'h0
`define FPSU_FW0_DOUBLE     4'h2
`define FPSU_FW0_SINGLE     4'h2
`define FPSU_FW0_REGFILE    4'h1

// ----------------------------------------------------------------------
// Feature word one nibbles, top down
// ----------------------------------------------------------------------
`define FPSU_FW1_FMAC       4'h1
`define FPSU_FW1_HALF       4'h1
`define FPSU_FW1_VEC_HALF   4'h0
`define FPSU_FW1_VEC_SGL    4'h0
`define FPSU_FW1_VEC_INT    4'h0
`define FPSU_FW1_VEC_LDST   4'h0
`define FPSU_FW1_NAN_PROP   4'h1
`define FPSU_FW1_DENORM     4'h1

`endif

// *** rtl/fpsu_pkg.sv ***
package fpsu_pkg;

    typedef enum logic [1:0]
    {
        FPSU_SEL_STATUS = 2'h0,
        FPSU_SEL_FW0    = 2'h1,
        FPSU_SEL_FW1    = 2'h2,
        FPSU_SEL_EXC    = 2'h3
    } fpsu_sel_e;

    typedef enum logic [1:0]
    {
        FPSU_NEAREST_ROUNDING   = 2'h0,
        FPSU_TOWARD_PLUS_INF    = 2'h1,
        FPSU_TOWARD_MINUS_INF   = 2'h2,
        FPSU_TOWARD_ZERO_ROUND  = 2'h3
    } fpsu_round_e;

    typedef struct packed
    {
        logic        valid;
        logic        write;
        fpsu_sel_e   sel;
        logic [31:0] wdata;
    } fpsu_req_s;

    typedef struct packed
    {
        logic       nonsecure;
        logic       privileged;
        logic       ns_slot_a;
        logic       ns_slot_b;
        logic [1:0] cp_slot_a;
        logic [1:0] cp_slot_b;
    } fpsu_ctx_s;

endpackage

// *** rtl/fpsu_flag_acc.sv ***
`timescale 1ns/100ps
`include "fpsu_defines.svh"

module fpsu_flag_acc
#(
    parameter int N = `FPSU_FLAG_COUNT
)
(
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic [N-1:0] raise,
    input  wire logic         wr_en,
    input  wire logic [N-1:0] wr_val,
    output logic      [N-1:0] flags
);

    // ------------------------------------------------------------------
    // One sticky flag per exception
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_flag
            logic next_flag;

            // A raise in the clearing cycle still lands
            always_comb
            begin
                next_flag = wr_en ? wr_val[i] : flags[i];
                next_flag = next_flag | raise[i];           // [R24]
            end

            always_ff @(posedge clk_sys or negedge nrst)
            begin
                if (!nrst)
                    flags[i] <= 1'b0;
                else
                    flags[i] <= next_flag;
            end
        end
    endgenerate

endmodule // fpsu_flag_acc

// *** rtl/fpsu_regs.sv ***
// Notes on behaviour
// R1: Rounding select in bits 23:22, four modes
// R2: Legacy vector step field in bits 21:20
// R3: Legacy vector count field in bits 18:16
// R4: Bit 7 sticky denormal input flag
// R5: Bit 4 sticky inexact flag
// R6: Bit 3 sticky underflow flag
// R7: Bit 2 sticky overflow flag
// R8: Bit 1 sticky divide by zero flag
// R9: Bit 0 sticky invalid operation flag
// R10: Core reads and writes whole status word
// R11: Nonsecure access needs both nonsecure slot bits
// R12: Feature words: privileged, coprocessor enabled, unit enabled
// R13: Word zero 31:28 reads 0x1
// R14: Word zero 27:24 reads 0x0
// R15: Word zero 23:20 reads 0x1
// R16: Word zero 19:16 reads 0x1
// R17: Word zero 15:12 reads 0x0
// R18: Word zero 11:8 reads 0x2
// R19: Word zero 7:4 reads 0x2
// R20: Word zero 3:0 reads 0x1
// R21: Feature word zero is read only
// R22: Feature word one fixed capability nibbles
// R23: Unit enable bit, cleared at reset
// R24: Flags stay set until written zero
// R25: Forbidden access changes nothing, answers undefined
`timescale 1ns/100ps
`include "fpsu_defines.svh"

module fpsu_regs
(
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire fpsu_pkg::fpsu_req_s   req,
    input  wire fpsu_pkg::fpsu_ctx_s   ctx,
    input  wire logic [5:0]            exc_raise,
    output logic                       rsp_valid,
    output logic                       rsp_undef,
    output logic [31:0]                rd_data,
    output fpsu_pkg::fpsu_round_e      rounding_select,
    output logic [1:0]                 vector_step,
    output logic [2:0]                 vector_count,
    output logic [5:0]                 exc_flags,
    output logic                       unit_enable
);
    import fpsu_pkg::*;

    // ------------------------------------------------------------------
    // Fixed feature words
    // ------------------------------------------------------------------
    localparam logic [31:0] FW0 =
    {
        `FPSU_FW0_ROUND,                                    // [R13]
        `FPSU_FW0_SHORTVEC,                                 // [R14]
        `FPSU_FW0_SQRT,                                     // [R15]
        `FPSU_FW0_DIVIDE,                                   // [R16]
        `FPSU_FW0_TRAP,                                     // [R17]
        `FPSU_FW0_DOUBLE,                                   // [R18]
        `FPSU_FW0_SINGLE,                                   // [R19]
        `FPSU_FW0_REGFILE                                   // [R20]
    };
    localparam logic [31:0] FW1 =
    {
        `FPSU_FW1_FMAC, `FPSU_FW1_HALF,                     // [R22]
        `FPSU_FW1_VEC_HALF, `FPSU_FW1_VEC_SGL,
        `FPSU_FW1_VEC_INT, `FPSU_FW1_VEC_LDST,
        `FPSU_FW1_NAN_PROP, `FPSU_FW1_DENORM
    };

    // ------------------------------------------------------------------
    // Access gating
    // ------------------------------------------------------------------
    logic ns_ok;
    logic cp_ok;
    logic access_ok;
    logic status_we;
    logic exc_we;

    function automatic logic slot_ok(input logic [1:0] f, input logic p);
        slot_ok = (f == `FPSU_CP_FULL) || (f == `FPSU_CP_PRIV_ONLY && p);
    endfunction

    always_comb
    begin
        ns_ok = !ctx.nonsecure || (ctx.ns_slot_a && ctx.ns_slot_b); // [R11]
        cp_ok = slot_ok(ctx.cp_slot_a, ctx.privileged) &&
                slot_ok(ctx.cp_slot_b, ctx.privileged);
        access_ok = 1'b0;
        if (req.sel == FPSU_SEL_STATUS)
            access_ok = ns_ok && cp_ok && unit_enable;
        else if (req.sel == FPSU_SEL_EXC)
            access_ok = ns_ok && cp_ok && ctx.privileged;
        else
            // Feature words cannot be written at all
            access_ok = ns_ok && cp_ok && ctx.privileged   // [R12]
                        && unit_enable && !req.write;       // [R21]
        status_we = req.valid && req.write && access_ok &&
                    req.sel == FPSU_SEL_STATUS;             // [R25]
        exc_we   = req.valid && req.write && access_ok &&
                   req.sel == FPSU_SEL_EXC;
    end

    // ------------------------------------------------------------------
    // Control fields and unit enable
    // ------------------------------------------------------------------
    fpsu_round_e next_rounding_select;
    logic [1:0]  next_vector_step;
    logic [2:0]  next_vector_count;
    logic        next_unit_enable;

    always_comb
    begin
        next_rounding_select = rounding_select;
        next_vector_step     = vector_step;
        next_vector_count    = vector_count;
        next_unit_enable     = unit_enable;
        if (status_we)                                      // [R10]
        begin
            next_rounding_select =
                fpsu_round_e'(req.wdata[`FPSU_RND_MSB:`FPSU_RND_LSB]); // [R1]
            next_vector_step  =
                req.wdata[`FPSU_STEP_MSB:`FPSU_STEP_LSB];   // [R2]
            next_vector_count =
                req.wdata[`FPSU_CNT_MSB:`FPSU_CNT_LSB];     // [R3]
        end
        if (exc_we)
            next_unit_enable = req.wdata[`FPSU_EN_BIT];     // [R23]
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rounding_select <= fpsu_round_e'(
                `FPSU_STATUS_RST >> `FPSU_RND_LSB);
            vector_step     <= 2'h0;
            vector_count    <= 3'h0;
            unit_enable     <= `FPSU_EN_RST;                // [R23]
        end
        else
        begin
            rounding_select <= next_rounding_select;
            vector_step     <= next_vector_step;
            vector_count    <= next_vector_count;
            unit_enable     <= next_unit_enable;
        end
    end

    // ------------------------------------------------------------------
    // Sticky exception flags
    // ------------------------------------------------------------------
    // Flag order: invalid, divz, over, under, inexact, denormal
    logic [5:0] wr_flags;

    assign wr_flags =
    {
        req.wdata[`FPSU_DENORM_BIT],                        // [R4]
        req.wdata[`FPSU_INEXACT_BIT],                       // [R5]
        req.wdata[`FPSU_UNDER_BIT],                         // [R6]
        req.wdata[`FPSU_OVER_BIT],                          // [R7]
        req.wdata[`FPSU_DIVZ_BIT],                          // [R8]
        req.wdata[`FPSU_INVALID_BIT]                        // [R9]
    };

    fpsu_flag_acc
    #(
        .N      (`FPSU_FLAG_COUNT)
    )
    u_flags
    (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .raise   (exc_raise),
        .wr_en   (status_we),                               // [R24]
        .wr_val  (wr_flags),
        .flags   (exc_flags)
    );

    // ------------------------------------------------------------------
    // Read path and answer
    // ------------------------------------------------------------------
    logic [31:0] status_view;
    logic [31:0] next_rd_data;
    logic        next_rsp_valid;
    logic        next_rsp_undef;

    always_comb
    begin
        // Upper status bits belong elsewhere and read zero here
        status_view = 32'h0000_0000;
        status_view[`FPSU_RND_MSB:`FPSU_RND_LSB]   = rounding_select;
        status_view[`FPSU_STEP_MSB:`FPSU_STEP_LSB] = vector_step;
        status_view[`FPSU_CNT_MSB:`FPSU_CNT_LSB]   = vector_count;
        status_view[`FPSU_DENORM_BIT]  = exc_flags[5];
        status_view[`FPSU_INEXACT_BIT] = exc_flags[4];
        status_view[`FPSU_UNDER_BIT]   = exc_flags[3];
        status_view[`FPSU_OVER_BIT]    = exc_flags[2];
        status_view[`FPSU_DIVZ_BIT]    = exc_flags[1];
        status_view[`FPSU_INVALID_BIT] = exc_flags[0];

        next_rsp_valid = req.valid;
        next_rsp_undef = req.valid && !access_ok;           // [R25]
        next_rd_data   = 32'h0000_0000;
        if (req.valid && access_ok && !req.write)
        begin
            if (req.sel == FPSU_SEL_STATUS)
                next_rd_data = status_view;                 // [R10]
            else if (req.sel == FPSU_SEL_FW0)
                next_rd_data = FW0;                         // [R21]
            else if (req.sel == FPSU_SEL_FW1)
                next_rd_data = FW1;                         // [R22]
            else
                next_rd_data[`FPSU_EN_BIT] = unit_enable;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rsp_valid <= 1'b0;
            rsp_undef <= 1'b0;
            rd_data   <= 32'h0000_0000;
        end
        else
        begin
            rsp_valid <= next_rsp_valid;
            rsp_undef <= next_rsp_undef;
            rd_data   <= next_rd_data;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    sequence s_read_fw0;
        req.valid && !req.write && req.sel == FPSU_SEL_FW0 && access_ok;
    endsequence

    sequence s_read_fw1;
        req.valid && !req.write && req.sel == FPSU_SEL_FW1 && access_ok;
    endsequence

    sequence s_status_write;
        req.valid && req.write && req.sel == FPSU_SEL_STATUS && access_ok;
    endsequence

    a_answer_next_cycle: assert property ( // [R10]
        req.valid |=> rsp_valid ##1 (rsp_valid == $past(req.valid)))
        else $error("answer not one cycle after request");

    a_fw0_value: assert property ( // [R13]
        s_read_fw0 |=> rsp_valid && !rsp_undef && rd_data == 32'h1011_0221)
        else $error("feature word zero read wrong");

    a_fw1_value: assert property ( // [R22]
        s_read_fw1 |=> rsp_valid && !rsp_undef && rd_data == 32'h1100_0011)
        else $error("feature word one read wrong");

    a_ns_gate: assert property ( // [R11]
        req.valid && ctx.nonsecure && !(ctx.ns_slot_a && ctx.ns_slot_b)
        |=> rsp_undef && rd_data == 32'h0000_0000)
        else $error("nonsecure access not refused");

    a_priv_en_gate: assert property ( // [R12]
        req.valid && req.sel == FPSU_SEL_FW0 &&
        (!ctx.privileged || !unit_enable) |=> rsp_undef)
        else $error("feature word gate open");

    a_denied_no_change: assert property ( // [R25]
        req.valid && req.write && !access_ok && exc_raise == 6'h0
        |=> $stable(rounding_select) && $stable(vector_count)
            && $stable(exc_flags) && $stable(unit_enable))
        else $error("refused write changed state");

    a_round_write: assert property ( // [R1]
        s_status_write |=> rounding_select == $past(req.wdata[23:22])
                           && vector_step == $past(req.wdata[21:20])
                           && vector_count == $past(req.wdata[18:16]))
        else $error("status write not stored");

    a_flag_set: assert property ( // [R24]
        exc_raise != 6'h0 |=> (exc_flags & $past(exc_raise))
                              == $past(exc_raise))
        else $error("raised exception not recorded");

    a_flag_sticky: assert property ( // [R24]
        exc_raise == 6'h0 && !status_we |=> $stable(exc_flags))
        else $error("flag changed without cause");

    a_enable_write: assert property ( // [R23]
        req.valid && req.write && req.sel == FPSU_SEL_EXC && access_ok
        |=> unit_enable == $past(req.wdata[30])
            ##1 ($stable(unit_enable) || $past(req.valid && req.write)))
        else $error("unit enable write lost");

endmodule // fpsu_regs

// *** sim/fpsu_core_model.sv ***
`timescale 1ns/100ps

module fpsu_core_model
(
    input  wire logic                clk_sys,
    output fpsu_pkg::fpsu_req_s      req,
    output fpsu_pkg::fpsu_ctx_s      ctx,
    input  wire logic                rsp_valid,
    input  wire logic                rsp_undef,
    input  wire logic [31:0]         rd_data
);
    import fpsu_pkg::*;

    initial
    begin
        req = '0;
        ctx = '0;
    end

    // ------------------------------------------------------------------
    // One move instruction, whole word, answer one cycle after
    // ------------------------------------------------------------------
    // Idle write data is inverted so a stale word is never mistaken
    task automatic move(input logic wr, input fpsu_sel_e sel,
                        input logic [31:0] wd, input fpsu_ctx_s c,
                        output logic v, output logic u,
                        output logic [31:0] rd);
        @(posedge clk_sys);
        #1;
        ctx       = c;
        req.valid = 1'b1;
        req.write = wr;
        req.sel   = sel;
        req.wdata = wd;
        @(posedge clk_sys);
        #1;
        req.valid = 1'b0;
        req.wdata = ~wd;
        v         = rsp_valid;
        u         = rsp_undef;
        rd        = rd_data;
    endtask
endmodule // fpsu_core_model

// *** sim/fp_unit_status_and_feature_regs_tb.sv ***
`timescale 1ns/100ps

module fp_unit_status_and_feature_regs_tb;
    import fpsu_pkg::*;

    logic                  clk_sys;
    logic                  nrst;
    fpsu_req_s             req;
    fpsu_ctx_s             ctx;
    logic [5:0]            exc_raise;
    logic                  rsp_valid;
    logic                  rsp_undef;
    logic [31:0]           rd_data;
    fpsu_round_e           rounding_select;
    logic [1:0]            vector_step;
    logic [2:0]            vector_count;
    logic [5:0]            exc_flags;
    logic                  unit_enable;
    int                    miscompares;
    int                    num_checks;
    integer                seed;
    logic [31:0]           m_scr;
    bit                    m_en;
    logic [31:0]           rd;
    fpsu_ctx_s             c;
    localparam fpsu_ctx_s  GOOD = fpsu_ctx_s'(8'hFF);

    fpsu_regs i_dut (.clk_sys(clk_sys), .nrst(nrst), .req(req), .ctx(ctx),
        .exc_raise(exc_raise), .rsp_valid(rsp_valid), .rsp_undef(rsp_undef),
        .rd_data(rd_data), .rounding_select(rounding_select),
        .vector_step(vector_step), .vector_count(vector_count),
        .exc_flags(exc_flags), .unit_enable(unit_enable));

    fpsu_core_model i_core (.clk_sys(clk_sys), .req(req), .ctx(ctx),
        .rsp_valid(rsp_valid), .rsp_undef(rsp_undef), .rd_data(rd_data));

    // ------------------------------------------------------------------
    // Reference model and checks
    // ------------------------------------------------------------------
    task automatic summarize;
        if (miscompares == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic bit slot_ok(logic [1:0] f, logic p);
        return f == 2'h3 || (f == 2'h1 && p);
    endfunction

    // Gating recomputed here, not shared with the design
    function automatic bit allowed(fpsu_ctx_s x, logic wr, fpsu_sel_e s);
        bit base;
        base = (!x.nonsecure || (x.ns_slot_a && x.ns_slot_b))
            && slot_ok(x.cp_slot_a, x.privileged)
            && slot_ok(x.cp_slot_b, x.privileged);
        case (s)
            FPSU_SEL_STATUS: return base && m_en;
            FPSU_SEL_EXC:    return base && x.privileged;
            default:         return base && x.privileged && m_en && !wr;
        endcase
    endfunction

    task automatic check_state;
        logic [5:0] f;
        f = {m_scr[7], m_scr[4:0]};
        chk(32'(rounding_select), 32'(m_scr[23:22]));
        chk(32'(vector_step), 32'(m_scr[21:20]));
        chk(32'(vector_count), 32'(m_scr[18:16]));
        chk(32'(exc_flags[5:3]), 32'(f[5:3]));
        chk(32'(exc_flags[2:0]), 32'(f[2:0]));
        chk(32'(unit_enable), 32'(m_en));
    endtask

    task automatic access(input logic wr, input fpsu_sel_e s,
                          input logic [31:0] wd, input fpsu_ctx_s x,
                          output logic [31:0] r);
        logic        v;
        logic        u;
        logic [31:0] exp_rd;
        bit          ok;
        ok     = allowed(x, wr, s);
        exp_rd = 32'h0;
        if (ok && !wr)
            case (s)
                FPSU_SEL_STATUS: exp_rd = m_scr;
                FPSU_SEL_FW0:    exp_rd = 32'h1011_0221;
                FPSU_SEL_FW1:    exp_rd = 32'h1100_0011;
                default:         exp_rd = {1'b0, m_en, 30'h0};
            endcase
        i_core.move(wr, s, wd, x, v, u, r);
        if (ok && wr && s == FPSU_SEL_STATUS)
            m_scr = wd & 32'h00F7_009F;
        if (ok && wr && s == FPSU_SEL_EXC)
            m_en = wd[30];
        chk(32'(v), 32'h1);
        chk(32'(u), 32'(!ok));
        chk(r, exp_rd);
        check_state;
    endtask

    task automatic raise(input logic [5:0] ev);
        @(posedge clk_sys);
        #1;
        exc_raise = ev;
        @(posedge clk_sys);
        #1;
        exc_raise = 6'h0;
        m_scr = m_scr | {24'h0, ev[5], 2'h0, ev[4:0]};
        check_state;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial
    begin
        #100000;
        miscompares++;
        summarize;
    end

    initial
    begin
        nrst        = 1'b0;
        exc_raise   = 6'h0;
        miscompares = 0;
        num_checks  = 0;
        seed        = 64079;
        m_scr       = 32'h0;
        m_en        = 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        check_state;
        // Unit still disabled: feature read and status write refused, then enable bit written and read
        access(1'b0, FPSU_SEL_FW0, 32'h0, GOOD, rd);
        access(1'b1, FPSU_SEL_STATUS, 32'hFFFF_FFFF, GOOD, rd);
        access(1'b1, FPSU_SEL_EXC, 32'hFFFF_FFFF, GOOD, rd);
        access(1'b0, FPSU_SEL_EXC, 32'h0, GOOD, rd);
        for (int i = 0; i < 4; i++)
        begin
            access(1'b1, FPSU_SEL_STATUS, 32'(i) << 22, GOOD, rd);
            access(1'b0, FPSU_SEL_STATUS, 32'h0, GOOD, rd);
        end
        access(1'b0, FPSU_SEL_FW0, 32'h0, GOOD, rd);
        chk(32'(rd[31:16]), 32'h0000_1011);
        chk(32'(rd[15:0]), 32'h0000_0221);
        access(1'b1, FPSU_SEL_FW0, 32'h0, GOOD, rd);
        access(1'b0, FPSU_SEL_FW1, 32'h0, GOOD, rd);
        chk(rd, 32'h1100_0011);
        access(1'b0, FPSU_SEL_FW0, 32'h0, fpsu_ctx_s'(8'hEF), rd);
        access(1'b0, FPSU_SEL_FW0, 32'h0, fpsu_ctx_s'(8'hBF), rd);
        access(1'b1, FPSU_SEL_STATUS, 32'h0, fpsu_ctx_s'(8'hBF), rd);
        for (int i = 0; i < 6; i++)
            raise(6'h1 << i);
        access(1'b1, FPSU_SEL_STATUS, 32'h0, fpsu_ctx_s'(8'hB5), rd);
        access(1'b1, FPSU_SEL_STATUS, 32'h0, GOOD, rd);
        for (int i = 0; i < 200; i++)
        begin
            c = GOOD;
            if ($random(seed) % 3 == 0)
                c = fpsu_ctx_s'(8'($random(seed)));
            access(1'($random(seed)), fpsu_sel_e'(2'($random(seed))),
                   $random(seed), c, rd);
            if ($random(seed) % 4 == 0)
                raise(6'($random(seed)));
        end
        summarize;
    end
endmodule // fp_unit_status_and_feature_regs_tb
